/* File: rtl/clock_speed_pkg.sv */
// constants shared by the clock speed selector and its reset qualifier
package clock_speed_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // register indices; byte address is four times the index
    localparam logic [7:0] CLOCK_SPEED_CONTROL_INDEX = 8'h8F;
    localparam logic [7:0] SPEED_STATUS_INDEX = 8'h90;
    localparam logic [ADDR_W-1:0] CLOCK_SPEED_CONTROL_ADDR = {2'h0, CLOCK_SPEED_CONTROL_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] SPEED_STATUS_ADDR = {2'h0, SPEED_STATUS_INDEX, 2'h0};
    // field positions
    localparam int DOUBLE_SPEED_SELECT_BIT = 0;
    localparam int STATUS_DOUBLE_APPLIED_BIT = 0;
    localparam int STATUS_DEVICE_RESET_BIT = 1;
    localparam logic CONTROL_RESET_VALUE = 1'h0;
    // machine cycle: six core clock periods, strobe at two of them
    localparam logic [2:0] MC_LAST_PHASE = 3'h5;
    localparam logic [2:0] ALE_PHASE_A = 3'h0;
    localparam logic [2:0] ALE_PHASE_B = 3'h3;
    localparam logic [1:0] RESET_MC_COUNT = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/reset_qualifier.sv */
// qualifies the reset pin over whole machine cycles
`timescale 1ns/10ps
module reset_qualifier
    import clock_speed_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic reset_pin,
    input wire logic machine_cycle_end,
    output logic device_reset
);
    import clock_speed_pkg::*;

    logic pin_meta;
    logic pin_sync;
    logic armed;
    logic [1:0] full_cycles;
    logic next_armed;
    logic [1:0] next_full_cycles;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            pin_meta <= reset_pin;
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------
    // machine cycle counter
    // ------------------------------------------------------------
    // the first cycle end only arms: the cycle in which the pin rose was partial
    always_comb
    begin
        next_armed = armed;
        next_full_cycles = full_cycles;
        if (!pin_sync)
        begin
            next_armed = 1'b0;
            next_full_cycles = 2'h0;
        end
        else if (machine_cycle_end)
        begin
            if (!armed)
                next_armed = 1'b1;
            else if (full_cycles != RESET_MC_COUNT)
                next_full_cycles = full_cycles + 2'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            armed <= 1'b0;
            full_cycles <= 2'h0;
        end
        else
        begin
            armed <= next_armed;
            full_cycles <= next_full_cycles;
        end
    end

    assign device_reset = (full_cycles == RESET_MC_COUNT);

    property p_reset_after_two_cycles;
        @(posedge aclk) disable iff (!aresetn)
        (pin_sync && armed && full_cycles == 2'h1 && machine_cycle_end) |=> device_reset;
    endproperty
    a_reset_after_two_cycles: assert property (p_reset_after_two_cycles) else $error("reset not raised after two cycles");

    property p_reset_needs_pin;
        @(posedge aclk) disable iff (!aresetn)
        device_reset |-> $past(pin_sync);
    endproperty
    a_reset_needs_pin: assert property (p_reset_needs_pin) else $error("reset raised without pin high");
endmodule

/* File: rtl/clock_speed_select.sv */
// selectable divide-by-two clock stage with address-latch strobe and register slave
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Overview of operation
// - reset after pin high two machine cycles
// - strobe at sixth or third of oscillator
// - skip one strobe per external data access
// - machine cycle 12 halved or 6 full periods
// - software can disable divide-by-two stage
// - halved clock feeds core, bypassed in double
// - mode change only at halved clock rise
// - after reset standard mode, bit cleared
// - peripheral time base follows selected clock
// - control register at 8Fh, byte access only; the code takes any write that strobes lane 0, word writes included
module clock_speed_select
    import clock_speed_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic reset_pin,
    input wire logic ext_data_access,
    output logic core_clk_en,
    output logic machine_cycle_end,
    output logic ale_strobe,
    output logic standard_speed_mode,
    output logic device_reset,
    input wire logic [clock_speed_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [clock_speed_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [clock_speed_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [clock_speed_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import clock_speed_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic double_speed_select;
    logic double_applied;
    logic div2;
    logic [2:0] mc_phase;
    logic skip_pending;
    logic next_double_speed_select;
    logic next_double_applied;
    logic next_div2;
    logic [2:0] next_mc_phase;
    logic next_skip_pending;
    logic next_core_clk_en;
    logic next_machine_cycle_end;
    logic next_ale_strobe;
    logic core_tick;
    logic ale_slot;

    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [DATA_W-1:0] next_w_data;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp;
    logic next_bvalid;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid;
    logic write_fire;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = (addr == CLOCK_SPEED_CONTROL_ADDR) || (addr == SPEED_STATUS_ADDR);
    endfunction

    // ------------------------------------------------------------
    // clock generation
    // ------------------------------------------------------------
    // aclk stands for the crystal; div2 low means the halved clock rises next
    assign core_tick = double_applied || !div2;
    assign ale_slot = core_tick && (mc_phase == ALE_PHASE_A || mc_phase == ALE_PHASE_B);

    always_comb
    begin
        next_div2 = !div2;
        // switching only at the halved clock rise keeps pulse widths whole
        next_double_applied = div2 ? double_applied : double_speed_select;
        next_mc_phase = mc_phase;
        if (core_tick)
            next_mc_phase = (mc_phase == MC_LAST_PHASE) ? 3'h0 : mc_phase + 3'h1;
        next_core_clk_en = core_tick;
        next_machine_cycle_end = core_tick && (mc_phase == MC_LAST_PHASE);
        next_ale_strobe = ale_slot && !skip_pending;
        next_skip_pending = skip_pending;
        if (ale_slot)
            next_skip_pending = 1'b0;
        if (ext_data_access)
            next_skip_pending = 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div2 <= 1'b0;
            double_applied <= 1'b0;
            mc_phase <= 3'h0;
            skip_pending <= 1'b0;
            core_clk_en <= 1'b0;
            machine_cycle_end <= 1'b0;
            ale_strobe <= 1'b0;
        end
        else
        begin
            div2 <= next_div2;
            double_applied <= next_double_applied;
            mc_phase <= next_mc_phase;
            skip_pending <= next_skip_pending;
            core_clk_en <= next_core_clk_en;
            machine_cycle_end <= next_machine_cycle_end;
            ale_strobe <= next_ale_strobe;
        end
    end

    assign standard_speed_mode = !double_applied;

    reset_qualifier u_reset_qualifier (
        .aclk(aclk),
        .aresetn(aresetn),
        .reset_pin(reset_pin),
        .machine_cycle_end(machine_cycle_end),
        .device_reset(device_reset)
    );

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    // address and data are held until both arrive, then the write is done
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        write_fire = next_aw_held && next_w_held && !s_axi_bvalid;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_double_speed_select = double_speed_select;
        if (write_fire)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(next_aw_addr) ? RESP_OKAY : RESP_SLVERR;
            // only the low byte lane carries the register; other lanes alone do nothing
            if (next_aw_addr == CLOCK_SPEED_CONTROL_ADDR && next_w_strb[0])
                next_double_speed_select = next_w_data[DOUBLE_SPEED_SELECT_BIT];
        end
        if (device_reset)
            next_double_speed_select = CONTROL_RESET_VALUE;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata = '0;
            next_rresp = RESP_OKAY;
            if (s_axi_araddr == CLOCK_SPEED_CONTROL_ADDR)
                next_rdata[DOUBLE_SPEED_SELECT_BIT] = double_speed_select;
            else if (s_axi_araddr == SPEED_STATUS_ADDR)
            begin
                next_rdata[STATUS_DOUBLE_APPLIED_BIT] = double_applied;
                next_rdata[STATUS_DEVICE_RESET_BIT] = device_reset;
            end
            else
                next_rresp = RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            double_speed_select <= CONTROL_RESET_VALUE;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            double_speed_select <= next_double_speed_select;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // gap between strobes, counted from the previous one
    // restarted on the edge that switches mode, so no measured gap spans two rates
    logic [3:0] ale_gap;
    logic gap_valid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || (double_applied != next_double_applied) || next_skip_pending)
        begin
            ale_gap <= 4'h0;
            gap_valid <= 1'b0;
        end
        else if (ale_strobe)
        begin
            ale_gap <= 4'h1;
            gap_valid <= 1'b1;
        end
        else if (ale_gap != 4'hF)
            ale_gap <= ale_gap + 4'h1;
    end

    property p_ale_rate;
        @(posedge aclk) disable iff (!aresetn)
        (ale_strobe && gap_valid) |-> (ale_gap == (double_applied ? 4'h3 : 4'h6));
    endproperty
    a_ale_rate: assert property (p_ale_rate) else $error("strobe spacing wrong for mode");

    property p_ale_skip;
        @(posedge aclk) disable iff (!aresetn)
        (ale_slot && skip_pending) |=> !ale_strobe;
    endproperty
    a_ale_skip: assert property (p_ale_skip) else $error("strobe not skipped");

    sequence s_access_taken;
        ext_data_access && !ale_slot;
    endsequence
    property p_skip_armed;
        @(posedge aclk) disable iff (!aresetn)
        s_access_taken |=> skip_pending;
    endproperty
    a_skip_armed: assert property (p_skip_armed) else $error("access did not arm skip");

    property p_standard_tick;
        @(posedge aclk) disable iff (!aresetn)
        (!double_applied && core_clk_en) ##1 !double_applied |-> !core_clk_en;
    endproperty
    a_standard_tick: assert property (p_standard_tick) else $error("core tick not halved in standard mode");

    property p_double_tick;
        @(posedge aclk) disable iff (!aresetn)
        (double_applied && $past(double_applied)) |=> core_clk_en;
    endproperty
    a_double_tick: assert property (p_double_tick) else $error("divider not bypassed in double mode");

    property p_mode_on_rise;
        @(posedge aclk) disable iff (!aresetn)
        $changed(double_applied) |-> ($past(div2) == 1'b0 && double_applied == $past(double_speed_select));
    endproperty
    a_mode_on_rise: assert property (p_mode_on_rise) else $error("mode changed off halved clock rise");

    property p_reset_clears;
        @(posedge aclk)
        !aresetn |=> (!double_speed_select && !double_applied);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset left double mode set");

    property p_byte_write;
        @(posedge aclk) disable iff (!aresetn)
        (write_fire && next_aw_addr == CLOCK_SPEED_CONTROL_ADDR && next_w_strb[0] && !device_reset)
            |=> double_speed_select == $past(next_w_data[DOUBLE_SPEED_SELECT_BIT]);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("control write not stored");
endmodule

/* File: verif/reset_source.sv */
// partner model: external reset circuit driving the device reset pin
`timescale 1ns/10ps
module reset_source
(
    input wire logic aclk,
    input wire logic machine_cycle_end,
    input wire logic start,
    input wire logic [3:0] hold_cycles,
    output logic reset_pin
);
    logic [3:0] left;

    initial
    begin
        reset_pin = 1'b0;
        left = 4'h0;
    end

    // pin held until the hold_cycles-th of the device's own cycle ends; the cycle in which it rises is partial
    always @(posedge aclk)
    begin
        if (start)
        begin
            reset_pin <= 1'b1;
            left <= hold_cycles;
        end
        else if (reset_pin && machine_cycle_end)
        begin
            left <= left - 4'h1;
            if (left == 4'h1)
                reset_pin <= 1'b0;
        end
    end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the clock speed selector
`timescale 1ns/10ps
module testbench;
    import clock_speed_pkg::*;
    // generous: the whole sequence needs well under a thousand cycles
    localparam int CEILING = 5000;
    logic aclk, aresetn, reset_pin, ext_data_access, core_clk_en, machine_cycle_end, ale_strobe;
    logic standard_speed_mode, device_reset, rst_start;
    logic [3:0] rst_hold, s_axi_wstrb;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_total, compares, cycles, n_ale, n_mc, n_ce, n_rst;

    clock_speed_select DUT (.aclk, .aresetn, .reset_pin, .ext_data_access, .core_clk_en, .machine_cycle_end,
        .ale_strobe, .standard_speed_mode, .device_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    reset_source partner (.aclk, .machine_cycle_end, .start(rst_start), .hold_cycles(rst_hold), .reset_pin);

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == CEILING)
        begin
            err_total++;
            $display("unexpected at %0t: run did not complete", $time);
            finish_test();
        end
    end

    // ----------------------------------------
    // bus and measurement tasks
    // ----------------------------------------
    // handshakes judged on what stands at each rising edge, before the design's own update
    task axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                b = 1'b1;
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask

    task axi_read(input logic [ADDR_W-1:0] a);
        logic r;
        r = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                r = 1'b1;
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    // counts pulses over a window that is a whole number of periods
    task count(input int n);
        n_ale = 0;
        n_mc = 0;
        n_ce = 0;
        n_rst = 0;
        repeat (n)
        begin
            @(negedge aclk);
            n_ale += (ale_strobe === 1'b1);
            n_mc += (machine_cycle_end === 1'b1);
            n_ce += (core_clk_en === 1'b1);
            n_rst += (device_reset === 1'b1);
        end
    endtask

    task pin_reset(input logic [3:0] ends);
        @(posedge aclk);
        rst_hold <= ends;
        rst_start <= 1'b1;
        @(posedge aclk);
        rst_start <= 1'b0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {aresetn, ext_data_access, rst_start, rst_hold, s_axi_wstrb} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        check(standard_speed_mode, 1'b1, "mode after reset");
        axi_read(CLOCK_SPEED_CONTROL_ADDR);
        check(rd, 32'h0, "control after reset");
        count(60);
        check(n_ale, 10, "strobes standard");
        check(n_mc, 5, "cycles standard");
        check(n_ce, 30, "core ticks standard");
        $display("test standard mode done");

        axi_write(CLOCK_SPEED_CONTROL_ADDR, 32'h1, 4'h1);
        check(resp, RESP_OKAY, "control write");
        repeat (4) @(posedge aclk);
        check(standard_speed_mode, 1'b0, "double mode applied");
        axi_read(CLOCK_SPEED_CONTROL_ADDR);
        check(rd, 32'h1, "control readback");
        axi_read(SPEED_STATUS_ADDR);
        check(rd, 32'h1, "status double");
        count(60);
        check(n_ale, 20, "strobes double");
        check(n_mc, 10, "cycles double");
        check(n_ce, 60, "core ticks double");
        $display("test double mode done");

        @(negedge aclk);
        while (ale_strobe !== 1'b1)
            @(negedge aclk);
        @(posedge aclk);
        ext_data_access <= 1'b1;
        @(posedge aclk);
        ext_data_access <= 1'b0;
        count(12);
        check(n_ale, 3, "strobe skipped");
        $display("test strobe skip done");

        axi_write(CLOCK_SPEED_CONTROL_ADDR, 32'h0, 4'h0);
        check(resp, RESP_OKAY, "write without byte lane");
        axi_read(CLOCK_SPEED_CONTROL_ADDR);
        check(rd, 32'h1, "control kept");
        axi_write(12'h100, 32'h1, 4'hF);
        check(resp, RESP_SLVERR, "unmapped write");
        axi_read(12'h100);
        check(resp, RESP_SLVERR, "unmapped read");
        check(rd, 32'h0, "unmapped data");
        $display("test register access done");

        pin_reset(4'h1);
        count(40);
        check(n_rst, 0, "short pin pulse ignored");
        pin_reset(4'h4);
        count(60);
        check(n_rst != 0, 1'b1, "pin reset in double mode");
        repeat (4) @(posedge aclk);
        check(standard_speed_mode, 1'b1, "mode after pin reset");
        axi_read(CLOCK_SPEED_CONTROL_ADDR);
        check(rd, 32'h0, "control after pin reset");
        count(60);
        check(n_ale, 10, "strobes after pin reset");
        $display("test pin reset done");
        finish_test();
    end
endmodule
